// ### src/mbpwm_defines.svh
// Purpose: Constants for the match based PWM generator: widths, counts, reset values.
// Assumes: Included by bare name from the package and the design modules.
// Notes:   Definitions only; the guard allows several inclusions.
//
// Functional notes
// - The counter advances on peripheral clock ticks and is compared with seven match values that raise actions or interrupt requests.
// - A 32-bit counter sits behind a programmable 32-bit prescaler that divides the clock.
// - In PWM mode a hit on the cycle match register restarts the count from zero and sets the common period.
// - Every single-edge output goes high when the cycle match register hits, at the start of each cycle.
// - A single-edge output falls when its own match register hits.
// - Each further single-edge output uses one more match register and shares the common period.
// - A double-edge output rises on one match register and falls on the next, neither being the cycle match register.
// - Each further double-edge output uses two more match registers and shares the common period.
// - A double-edge output gives a positive pulse when its rise count comes first and a negative pulse when its fall count comes first.
// - A match can leave the counter running and optionally request an interrupt.
// - A match can halt the counter and optionally request an interrupt.
// - A match can reset the counter to zero and optionally request an interrupt.
// - New match values act only after software releases them and, in PWM mode, only at a cycle boundary or a counter reset.
// - With PWM mode off the block is a plain timer with match functions only.
// - A single-edge output whose fall coincides with the cycle match stays low instead of rising.
`ifndef MBPWM_DEFINES_SVH
`define MBPWM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define MBPWM_CNT_W      32
`define MBPWM_NUM_MATCH  7
`define MBPWM_NUM_OUT    6
`define MBPWM_CYCLE_IDX  0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MBPWM_CNT_RST    32'h0000_0000
`define MBPWM_MATCH_RST  32'h0000_0000
`define MBPWM_FLAG_RST   7'h00
`define MBPWM_OUT_RST    6'h00

`endif

// ### src/mbpwm_pkg.sv
// Purpose: Types shared by the PWM generator modules.
// Assumes: Constants come from mbpwm_defines.svh.
// Notes:   Each module keeps all of its state in one struct from here.
`include "mbpwm_defines.svh"

package mbpwm_pkg;

  typedef logic [`MBPWM_CNT_W-1:0] mbpwm_word_type;
  typedef logic [`MBPWM_NUM_MATCH-1:0][`MBPWM_CNT_W-1:0] mbpwm_match_array_type;

  // ----------------------------------------------------------------------------
  // Counter run states
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MBPWM_IDLE,
    MBPWM_RUN,
    MBPWM_HALT
  } mbpwm_run_type;

  typedef struct packed {
    mbpwm_word_type count;
  } mbpwm_presc_state_type;

  typedef struct packed {
    mbpwm_match_array_type          active;
    logic [`MBPWM_NUM_MATCH-1:0]    pending;
  } mbpwm_shadow_state_type;

  typedef struct packed {
    mbpwm_run_type                  run;
    mbpwm_word_type                 count;
    logic [`MBPWM_NUM_OUT:1]        pwm;
    logic [`MBPWM_NUM_MATCH-1:0]    hit;
    logic [`MBPWM_NUM_MATCH-1:0]    irq;
    logic                           halted;
  } mbpwm_main_state_type;

endpackage

// ### src/mbpwm_prescaler.sv
// Purpose: Prescale divider that produces one advance strobe per prescale period.
// Assumes: All inputs come from logic on mclk.
// Notes:   A prescale value of zero gives a strobe on every running clock.
`timescale 1ns/100ps
`include "mbpwm_defines.svh"

module mbpwm_prescaler (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        run,
  input  wire logic                        clear,
  input  wire mbpwm_pkg::mbpwm_word_type   prescaleValue,
  output mbpwm_pkg::mbpwm_word_type        count,
  output logic                             tick
);

  mbpwm_pkg::mbpwm_presc_state_type state;
  mbpwm_pkg::mbpwm_presc_state_type next_state;

  assign count = state.count;
  assign tick  = run && (state.count == prescaleValue);

  always_comb begin
    next_state = state;
    if (clear) begin
      next_state.count = `MBPWM_CNT_RST;
    end else if (tick) begin
      next_state.count = `MBPWM_CNT_RST;
    end else if (run) begin
      next_state.count = state.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state.count <= `MBPWM_CNT_RST;
    end else begin
      state <= next_state;
    end
  end

endmodule

// ### src/mbpwm_match_shadow.sv
// Purpose: Active copies of the seven match values, loaded only after release.
// Assumes: Software holds each matchValue steady from release until it is applied.
// Notes:   Values are taken from the port at the moment of application.
`timescale 1ns/100ps
`include "mbpwm_defines.svh"

module mbpwm_match_shadow (
  input  wire logic                                mclk,
  input  wire logic                                rst_b,
  input  wire mbpwm_pkg::mbpwm_match_array_type    matchValue,
  input  wire logic [`MBPWM_NUM_MATCH-1:0]         latchRequest,
  input  wire logic                                applyNow,
  output mbpwm_pkg::mbpwm_match_array_type         activeMatch,
  output logic [`MBPWM_NUM_MATCH-1:0]              latchPending
);

  mbpwm_pkg::mbpwm_shadow_state_type state;
  mbpwm_pkg::mbpwm_shadow_state_type next_state;

  assign activeMatch  = state.active;
  assign latchPending = state.pending;

  always_comb begin
    logic [`MBPWM_NUM_MATCH-1:0] released;
    released   = state.pending | latchRequest;
    next_state = state;
    next_state.pending = released;
    if (applyNow) begin
      // A release in the same cycle as the apply is taken now, not lost
      for (int i = 0; i < `MBPWM_NUM_MATCH; i++) begin
        if (released[i]) begin
          next_state.active[i] = matchValue[i];
        end
      end
      next_state.pending = `MBPWM_FLAG_RST;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state.active  <= {`MBPWM_NUM_MATCH{`MBPWM_MATCH_RST}};
      state.pending <= `MBPWM_FLAG_RST;
    end else begin
      state <= next_state;
    end
  end

endmodule

// ### src/mbpwm_generator.sv
// Purpose: Timer with seven match registers and six PWM outputs; output 1 is single edge, outputs 2 to 6 single or double edge.
// Assumes: Configuration ports are driven by logic on mclk and held as levels.
// Notes:   Match 0 is the cycle match; output n falls on match n and, when
//          double edged, rises on match n-1.
`timescale 1ns/100ps
`include "mbpwm_defines.svh"

module mbpwm_generator (
  input  wire logic                                mclk,
  input  wire logic                                rst_b,
  input  wire logic                                counterEnable,
  input  wire logic                                counterReset,
  input  wire logic                                pwmEnable,
  input  wire mbpwm_pkg::mbpwm_word_type           prescaleValue,
  input  wire mbpwm_pkg::mbpwm_match_array_type    matchValue,
  input  wire logic [`MBPWM_NUM_MATCH-1:0]         latchRequest,
  input  wire logic [`MBPWM_NUM_MATCH-1:0]         matchIrqEnable,
  input  wire logic [`MBPWM_NUM_MATCH-1:0]         matchResetEnable,
  input  wire logic [`MBPWM_NUM_MATCH-1:0]         matchStopEnable,
  input  wire logic [`MBPWM_NUM_OUT:2]             doubleEdgeSelect,
  input  wire logic [`MBPWM_NUM_OUT:1]             outputEnable,
  output logic [`MBPWM_NUM_OUT:1]                  pwmOut,
  output mbpwm_pkg::mbpwm_word_type                timerCount,
  output mbpwm_pkg::mbpwm_word_type                prescaleCount,
  output logic [`MBPWM_NUM_MATCH-1:0]              matchHit,
  output logic [`MBPWM_NUM_MATCH-1:0]              matchIrq,
  output logic                                     counterHalted,
  output logic [`MBPWM_NUM_MATCH-1:0]              latchPending
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  mbpwm_pkg::mbpwm_main_state_type   state;
  mbpwm_pkg::mbpwm_main_state_type   next_state;
  mbpwm_pkg::mbpwm_match_array_type  activeMatch;
  logic                              tick;
  logic                              running;
  logic [`MBPWM_NUM_MATCH-1:0]       hitNow;
  logic                              cycleHit;
  logic                              applyNow;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [`MBPWM_NUM_MATCH-1:0] match_hits(
    input mbpwm_pkg::mbpwm_match_array_type values,
    input mbpwm_pkg::mbpwm_word_type        count,
    input logic                             strobe
  );
    logic [`MBPWM_NUM_MATCH-1:0] hits;
    hits = '0;
    for (int i = 0; i < `MBPWM_NUM_MATCH; i++) begin
      hits[i] = strobe && (values[i] == count);
    end
    return hits;
  endfunction

  // Set and clear for one output; the clear wins so that a fall landing on the
  // same tick as the rise gives a constant low rather than a runt pulse.
  function automatic logic edge_update(
    input logic current,
    input logic setHit,
    input logic clearHit
  );
    logic result;
    result = current;
    if (setHit) begin
      result = 1'b1;
    end
    if (clearHit) begin
      result = 1'b0;
    end
    return result;
  endfunction

  // ----------------------------------------------------------------------------
  // Prescaler and released match values
  // ----------------------------------------------------------------------------
  assign running = (state.run == mbpwm_pkg::MBPWM_RUN) && !counterReset;

  mbpwm_prescaler u_prescaler (
    .mclk          (mclk),
    .rst_b         (rst_b),
    .run           (running),
    .clear         (counterReset),
    .prescaleValue (prescaleValue),
    .count         (prescaleCount),
    .tick          (tick)
  );

  assign hitNow   = match_hits(activeMatch, state.count, tick);
  assign cycleHit = hitNow[`MBPWM_CYCLE_IDX];

  // In timer mode a release acts at once; in PWM mode it waits for the cycle
  // boundary, or for a counter reset when no cycle is running.
  assign applyNow = !pwmEnable || cycleHit || counterReset;

  mbpwm_match_shadow u_shadow (
    .mclk         (mclk),
    .rst_b        (rst_b),
    .matchValue   (matchValue),
    .latchRequest (latchRequest),
    .applyNow     (applyNow),
    .activeMatch  (activeMatch),
    .latchPending (latchPending)
  );

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign pwmOut        = state.pwm;
  assign timerCount    = state.count;
  assign matchHit      = state.hit;
  assign matchIrq      = state.irq;
  assign counterHalted = state.halted;

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    logic                        resetHit;
    logic                        stopHit;
    logic                        setHit;
    logic                        clearHit;
    logic [`MBPWM_NUM_OUT:1]     nextPwm;
    resetHit = |(hitNow & matchResetEnable);
    stopHit  = |(hitNow & matchStopEnable);
    setHit   = 1'b0;
    clearHit = 1'b0;
    nextPwm  = state.pwm;
    next_state = state;

    // Reported hits and interrupt requests last one cycle each
    next_state.hit = hitNow;
    next_state.irq = hitNow & matchIrqEnable;

    // Cycle match restarts the period whenever PWM mode is on
    if (pwmEnable && cycleHit) begin
      resetHit = 1'b1;
    end

    case (state.run)
      mbpwm_pkg::MBPWM_IDLE: begin
        if (counterEnable) begin
          next_state.run = mbpwm_pkg::MBPWM_RUN;
        end
      end
      mbpwm_pkg::MBPWM_RUN: begin
        if (!counterEnable) begin
          next_state.run = mbpwm_pkg::MBPWM_IDLE;
        end else if (stopHit) begin
          next_state.run = mbpwm_pkg::MBPWM_HALT;
        end
      end
      mbpwm_pkg::MBPWM_HALT: begin
        // Software restarts a halted counter by dropping and raising the enable
        if (!counterEnable) begin
          next_state.run = mbpwm_pkg::MBPWM_IDLE;
        end
      end
      default: begin
        next_state.run = mbpwm_pkg::MBPWM_IDLE;
      end
    endcase
    // Registered copy so the halt status pin comes straight from a flop
    next_state.halted = (next_state.run == mbpwm_pkg::MBPWM_HALT);

    // Counter: reset beats stop beats advance
    if (counterReset) begin
      next_state.count = `MBPWM_CNT_RST;
    end else if (resetHit) begin
      next_state.count = `MBPWM_CNT_RST;
    end else if (stopHit) begin
      next_state.count = state.count;
    end else if (tick) begin
      next_state.count = state.count + 32'h0000_0001;
    end

    // Outputs: output n always falls on match n; the rise comes either from
    // the cycle match or, when double edged, from match n-1.
    // Output 1 has no double edge option
    nextPwm[1] = edge_update(state.pwm[1], cycleHit, hitNow[1]);
    for (int n = 2; n <= `MBPWM_NUM_OUT; n++) begin
      if (doubleEdgeSelect[n]) begin
        setHit = hitNow[n-1];
      end else begin
        setHit = cycleHit;
      end
      clearHit = hitNow[n];
      // Clear wins, so a fall on the cycle match keeps the output low
      nextPwm[n] = edge_update(state.pwm[n], setHit, clearHit);
    end

    // Timer mode, or a disabled channel, keeps the pin low
    if (!pwmEnable) begin
      next_state.pwm = `MBPWM_OUT_RST;
    end else begin
      next_state.pwm = nextPwm & outputEnable;
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state.run   <= mbpwm_pkg::MBPWM_IDLE;
      state.count <= `MBPWM_CNT_RST;
      state.pwm   <= `MBPWM_OUT_RST;
      state.hit   <= `MBPWM_FLAG_RST;
      state.irq   <= `MBPWM_FLAG_RST;
      state.halted <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

endmodule

// ### tb/mbpwm_load_model.sv
// Purpose: Load on the PWM pins; measures the last high and low spans of each output.
// Assumes: One clock with the generator; spans counted in mclk cycles.
// Notes:   A span is recorded only when the pin changes, so a pin that never rises keeps 0.
`timescale 1ns/100ps

module mbpwm_load_model (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [6:1]       pwmIn,
  output logic      [6:1][31:0] highLen,
  output logic      [6:1][31:0] lowLen
);
  logic [6:1][31:0] span;
  logic [6:1]       last;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      highLen <= '0;
      lowLen  <= '0;
      span    <= '0;
      last    <= '0;
    end else begin
      for (int n = 1; n <= 6; n++) begin
        if (pwmIn[n] != last[n]) begin
          if (last[n]) highLen[n] <= span[n];
          else lowLen[n] <= span[n];
          span[n] <= 32'h1;
        end else begin
          span[n] <= span[n] + 32'h1;
        end
      end
      last <= pwmIn;
    end
  end
endmodule

// ### tb/mbpwm_generator_assertions.sv
// Purpose: Port level checks of the PWM generator.
// Assumes: Configuration stays steady while the counter runs.
// Notes:   Edge checks watch outputs 1 and 4 only, to keep the run cheap.
`timescale 1ns/100ps
`include "mbpwm_defines.svh"

module mbpwm_generator_checker (
  input wire logic                        mclk,
  input wire logic                        rst_b,
  input wire logic                        counterEnable,
  input wire logic                        counterReset,
  input wire logic                        pwmEnable,
  input wire mbpwm_pkg::mbpwm_word_type   prescaleValue,
  input wire logic [`MBPWM_NUM_MATCH-1:0] latchRequest,
  input wire logic [`MBPWM_NUM_OUT:2]     doubleEdgeSelect,
  input wire logic [`MBPWM_NUM_OUT:1]     outputEnable,
  input wire logic [`MBPWM_NUM_OUT:1]     pwmOut,
  input wire mbpwm_pkg::mbpwm_word_type   timerCount,
  input wire mbpwm_pkg::mbpwm_word_type   prescaleCount,
  input wire logic [`MBPWM_NUM_MATCH-1:0] matchHit,
  input wire logic [`MBPWM_NUM_MATCH-1:0] matchIrq,
  input wire logic                        counterHalted,
  input wire logic [`MBPWM_NUM_MATCH-1:0] latchPending
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ---------------------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------------------
  sequence s_run;
    counterEnable && $past(counterEnable) && !counterHalted && !counterReset;
  endsequence
  sequence s_pwm;
    pwmEnable && $past(pwmEnable);
  endsequence

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  property p_irq; (matchIrq & ~matchHit) == '0; endproperty
  property p_presc; s_run ##0 prescaleCount < prescaleValue
    |=> prescaleCount == $past(prescaleCount) + 1; endproperty
  property p_tick; s_run ##0 prescaleCount == prescaleValue |=> prescaleCount == 0; endproperty
  property p_hold; counterReset |=> timerCount == 0 && prescaleCount == 0; endproperty
  property p_idle; !counterEnable [*2] ##0 !counterReset |=> $stable(timerCount); endproperty
  property p_stop; counterHalted && !counterReset |=> $stable(timerCount); endproperty
  property p_timer; !pwmEnable [*2] |-> pwmOut == '0; endproperty
  property p_restart; s_pwm ##0 matchHit[0] |-> timerCount == 0; endproperty
  property p_rise; s_pwm ##0 matchHit[0] && !matchHit[1] && outputEnable[1] |-> pwmOut[1];
  endproperty
  property p_fall; s_pwm ##0 matchHit[1] |-> !pwmOut[1]; endproperty
  property p_dbl; s_pwm ##0 (matchHit[3] || matchHit[4]) && doubleEdgeSelect[4]
    && outputEnable[4] |-> pwmOut[4] == !matchHit[4]; endproperty
  property p_sync; s_pwm ##0 $fell(latchPending[1]) && !$past(counterReset) |-> matchHit[0];
  endproperty
  property p_direct; latchRequest[3] && !pwmEnable |=> !latchPending[3]; endproperty

  a_irq: assert property (p_irq) else $error("irq without hit");
  a_presc: assert property (p_presc) else $error("prescaler step");
  a_tick: assert property (p_tick) else $error("prescaler clear");
  a_hold: assert property (p_hold) else $error("reset hold");
  a_idle: assert property (p_idle) else $error("count while idle");
  a_stop: assert property (p_stop) else $error("count while halted");
  a_timer: assert property (p_timer) else $error("pwm out in timer mode");
  a_restart: assert property (p_restart) else $error("no restart");
  a_rise: assert property (p_rise) else $error("no cycle rise");
  a_fall: assert property (p_fall) else $error("no fall");
  a_dbl: assert property (p_dbl) else $error("double edge");
  a_sync: assert property (p_sync) else $error("apply off cycle");
  a_direct: assert property (p_direct) else $error("apply late");
endmodule

bind mbpwm_generator mbpwm_generator_checker chk (.mclk, .rst_b, .counterEnable,
  .counterReset, .pwmEnable, .prescaleValue, .latchRequest, .doubleEdgeSelect,
  .outputEnable, .pwmOut, .timerCount, .prescaleCount, .matchHit, .matchIrq,
  .counterHalted, .latchPending);

// ### tb/match_based_pwm_generator_tb.sv
// Purpose: Self-checking bench for the PWM generator.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes:   Match table serves both the timer and the PWM tests.
`timescale 1ns/100ps

module match_based_pwm_generator_tb;
  logic                            mclk, rst_b, counterEnable, counterReset, pwmEnable;
  mbpwm_pkg::mbpwm_word_type       prescaleValue, timerCount, prescaleCount;
  mbpwm_pkg::mbpwm_match_array_type matchValue;
  logic [6:0]                      latchRequest, matchIrqEnable, matchResetEnable;
  logic [6:0]                      matchStopEnable, matchHit, matchIrq, latchPending;
  logic [6:2]                      doubleEdgeSelect;
  logic [6:1]                      outputEnable, pwmOut;
  logic                            counterHalted;
  logic [6:1][31:0]                highLen, lowLen;
  int                              fails, checks, n;
  int                              mv [7] = '{9, 3, 9, 2, 6, 7, 1};

  mbpwm_generator dut (.mclk, .rst_b, .counterEnable, .counterReset, .pwmEnable,
    .prescaleValue, .matchValue, .latchRequest, .matchIrqEnable, .matchResetEnable,
    .matchStopEnable, .doubleEdgeSelect, .outputEnable, .pwmOut, .timerCount,
    .prescaleCount, .matchHit, .matchIrq, .counterHalted, .latchPending);
  mbpwm_load_model load (.mclk, .rst_b, .pwmIn(pwmOut), .highLen, .lowLen);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task waitHit(input int i, output int k);
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (matchHit[i] !== 1'b1 && k < 300);
    check(matchHit[i], 1'b1);
  endtask

  task setm(input int i, input int v);
    @(posedge mclk);
    matchValue[i] <= 32'(v);
    latchRequest[i] <= 1'b1;
    @(posedge mclk);
    latchRequest[i] <= 1'b0;
  endtask

  task wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    {rst_b, counterEnable, counterReset, pwmEnable} = 4'h0;
    {prescaleValue, matchValue, latchRequest, matchIrqEnable} = '0;
    {matchResetEnable, matchStopEnable, doubleEdgeSelect} = '0;
    outputEnable = 6'h3f;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    #1;
    check(timerCount, 32'h0);
    check(pwmOut, 6'h0);
    for (int i = 0; i < 7; i++) setm(i, mv[i]);
    #1;
    check(latchPending, 7'h0);
    $display("reset and load test done");
    // Stop on match 4 with its request enabled; prescale divides by three
    @(posedge mclk);
    prescaleValue <= 32'h2;
    matchStopEnable[4] <= 1'b1;
    matchIrqEnable[4] <= 1'b1;
    counterEnable <= 1'b1;
    waitHit(4, n);
    check(timerCount, 32'h6);
    check(matchIrq[4], 1'b1);
    repeat (12) @(posedge mclk);
    #1;
    check(counterHalted, 1'b1);
    check(timerCount, 32'h6);
    check(pwmOut, 6'h0);
    $display("timer stop test done");
    // Reset on match 5, no request, prescale divides by two
    @(posedge mclk);
    {counterEnable, counterReset} <= 2'h1;
    matchStopEnable <= 7'h0;
    matchResetEnable[5] <= 1'b1;
    prescaleValue <= 32'h1;
    @(posedge mclk);
    {counterEnable, counterReset} <= 2'h2;
    waitHit(5, n);
    check(timerCount, 32'h0);
    check(matchIrq[5], 1'b0);
    waitHit(5, n);
    check(n, 32'd16);
    $display("timer reset test done");
    // PWM mode: outputs 4 and 6 double edged
    @(posedge mclk);
    {counterEnable, counterReset, pwmEnable} <= 3'h3;
    matchResetEnable <= 7'h0;
    prescaleValue <= 32'h0;
    doubleEdgeSelect <= 5'h14;
    @(posedge mclk);
    {counterEnable, counterReset} <= 2'h2;
    repeat (60) @(posedge mclk);
    #1;
    check(highLen[1], 32'd4);
    check(lowLen[1], 32'd6);
    check(highLen[2], 32'd0);
    check(highLen[4], 32'd4);
    check(lowLen[6], 32'd6);
    waitHit(4, n);
    check(matchIrq[4], 1'b1);
    check(timerCount, 32'h7);
    check(counterHalted, 1'b0);
    $display("pwm edge test done");
    // New fall point for output 1 waits for the next cycle match
    waitHit(0, n);
    setm(1, 5);
    #1;
    check(latchPending[1], 1'b1);
    waitHit(0, n);
    check(latchPending[1], 1'b0);
    repeat (25) @(posedge mclk);
    #1;
    check(highLen[1], 32'd6);
    $display("release test done");
    wrap_up();
  end

  initial begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule
